/* hw/clz_pkg.sv */
// Purpose: Shared constants for the compare and leading-zero unit
// Assumes: 32-bit or 64-bit implementation chosen by a constant
// Notes:   Condition field bit positions follow the block's big-endian field numbering
package clz_pkg;
  localparam int unsigned WORD_W    = 64;
  localparam int unsigned IMM_W     = 16;
  localparam int unsigned FIELD_W   = 4;
  localparam int unsigned FSEL_W    = 3;
  localparam int unsigned NFIELDS   = 8;
  localparam int unsigned CNT_W     = 7;
  localparam int unsigned CR_W      = FIELD_W * NFIELDS;
  localparam int unsigned HALF_W    = 32;
  localparam logic [CNT_W-1:0]  CNTW_MAX    = 7'h20;
  // Field bit indices: bit 0 is the leftmost (most significant) bit of the field
  localparam int unsigned BIT_LT    = 0;
  localparam int unsigned BIT_GT    = 1;
  localparam int unsigned BIT_EQ    = 2;
  localparam int unsigned BIT_SO    = 3;
  localparam logic [FSEL_W-1:0] FIRST_FIELD = 3'h0;
  localparam logic [CR_W-1:0]   CR_RST      = 32'h0000_0000;
  localparam logic [WORD_W-1:0] GPR_RST     = 64'h0000_0000_0000_0000;
  localparam logic [IMM_W-1:0]  IMM_UPPER   = 16'h0000;
  localparam logic              IMPL_64     = 1'b1;

  typedef enum logic [5:0] {
    CLZ_OP_NONE = 6'h01,
    CLZ_OP_CMPI = 6'h02,
    CLZ_OP_CMPL = 6'h04,
    CLZ_OP_CMPLI= 6'h08,
    CLZ_OP_CNTW = 6'h10,
    CLZ_OP_CNTD = 6'h20
  } clz_op_e;
endpackage : clz_pkg

/* hw/clz_unit.sv */
// Purpose: Compare (signed imm, unsigned reg, unsigned imm) and leading-zero count slice
// Assumes: Decoded operands arrive with op_valid for one cycle; results register one cycle later
// Notes:   Condition register is held here as eight 4-bit fields, field 0 leftmost
// Contract
// - Signed-immediate compare: left gpr versus sign-extended 16-bit immediate, one flag.
// - Unsigned register compare of left and right gpr, one flag set.
// - Unsigned-immediate compare zero-extends the 16-bit immediate before comparing.
// - Field bits: 0 less, 1 greater, 2 equal, 3 summary overflow copy.
// - Three-bit selector picks condition field zero through seven for compares.
// - Compares never alter exception register; field zero changes only if selected.
// - Word count: leading zeros from bit 0 MSB, result 0 to 32.
// - Word count with record updates field zero; without, field zero untouched.
// - Doubleword count: leading zeros of 64-bit source, result 0 to 64.
// - On 32-bit implementation doubleword count raises illegal-instruction instead.
// - Recorded doubleword count updates field zero with less-than always cleared.
`timescale 1ns/100ps
module clz_unit
  import clz_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              op_valid,
  input  wire clz_op_e           op_sel,
  input  wire logic              width_sel,
  input  wire logic [FSEL_W-1:0] target_cr_field_sel,
  input  wire logic [WORD_W-1:0] left_input_gpr,
  input  wire logic [WORD_W-1:0] right_input_gpr,
  input  wire logic [WORD_W-1:0] count_input_gpr,
  input  wire logic [IMM_W-1:0]  imm_field,
  input  wire logic              record_flag,
  input  wire logic              xer_summary_ovf,
  output logic [CR_W-1:0]        cond_reg,
  output logic [WORD_W-1:0]      count_result,
  output logic                   count_wr,
  output logic                   cr_wr,
  output logic                   illegal_instr
);

  logic [CR_W-1:0]    cr_q;
  logic [CR_W-1:0]    cr_d;
  logic [WORD_W-1:0]  res_q;
  logic [WORD_W-1:0]  res_d;
  logic               cnt_wr_q;
  logic               cnt_wr_d;
  logic               cr_wr_q;
  logic               cr_wr_d;
  logic               ill_q;
  logic               ill_d;

  logic [WORD_W-1:0]  lhs;
  logic [WORD_W-1:0]  rhs;
  logic [WORD_W-1:0]  zero_extended_imm;
  logic [WORD_W-1:0]  sext_imm;
  logic [WORD_W-1:0]  cnt_src;
  logic [CNT_W-1:0]   lz_cnt;
  logic               less_than_flag;
  logic               greater_than_flag;
  logic               same_value_flag;
  logic               is_cmp;
  logic               is_cnt;
  logic               use_signed;
  logic               cnt_64;
  logic [FIELD_W-1:0] field_val;
  logic [FSEL_W-1:0]  dest_field;
  logic               do_cr;

  // Width-select 0 compares the low words; 1 compares full doublewords
  function automatic logic [WORD_W-1:0] narrow(input logic [WORD_W-1:0] v, input logic sgn, input logic wide);
    if (wide) begin
      narrow = v;
    end else if (sgn) begin
      narrow = {{(WORD_W-HALF_W){v[HALF_W-1]}}, v[HALF_W-1:0]};
    end else begin
      narrow = {{(WORD_W-HALF_W){1'b0}}, v[HALF_W-1:0]};
    end
  endfunction : narrow

  always_comb begin
    sext_imm          = {{(WORD_W-IMM_W){imm_field[IMM_W-1]}}, imm_field};
    zero_extended_imm = {{(WORD_W-2*IMM_W){1'b0}}, IMM_UPPER, imm_field};
    is_cmp     = (op_sel == CLZ_OP_CMPI) || (op_sel == CLZ_OP_CMPL) || (op_sel == CLZ_OP_CMPLI);
    is_cnt     = (op_sel == CLZ_OP_CNTW) || (op_sel == CLZ_OP_CNTD);
    use_signed = (op_sel == CLZ_OP_CMPI);
    cnt_64     = (op_sel == CLZ_OP_CNTD);
    lhs = narrow(left_input_gpr, use_signed, width_sel & IMPL_64);
    unique case (op_sel)
      CLZ_OP_CMPI:  rhs = narrow(sext_imm, 1'b1, width_sel & IMPL_64);
      CLZ_OP_CMPL:  rhs = narrow(right_input_gpr, 1'b0, width_sel & IMPL_64);
      CLZ_OP_CMPLI: rhs = zero_extended_imm;
      default:      rhs = GPR_RST;
    endcase
    if (use_signed) begin
      less_than_flag    = $signed(lhs) < $signed(rhs);
      greater_than_flag = $signed(lhs) > $signed(rhs);
    end else begin
      less_than_flag    = lhs < rhs;
      greater_than_flag = lhs > rhs;
    end
    same_value_flag = (lhs == rhs);
    // Word count looks at the low word only, placed at the top of the scan
    cnt_src = cnt_64 ? count_input_gpr : {count_input_gpr[HALF_W-1:0], {HALF_W{1'b1}}};
    lz_cnt  = CNT_W'(WORD_W);
    for (int i = 0; i < WORD_W; i++) begin
      if (cnt_src[i]) lz_cnt = CNT_W'(WORD_W - 1 - i);
    end
    if (!cnt_64 && lz_cnt > CNTW_MAX) lz_cnt = CNTW_MAX;
  end

  always_comb begin
    cr_d       = cr_q;
    res_d      = res_q;
    cnt_wr_d   = 1'b0;
    cr_wr_d    = 1'b0;
    ill_d      = 1'b0;
    field_val  = 4'h0;
    dest_field = FIRST_FIELD;
    do_cr      = 1'b0;
    if (op_valid && is_cmp) begin
      field_val[FIELD_W-1-BIT_LT] = less_than_flag;
      field_val[FIELD_W-1-BIT_GT] = greater_than_flag;
      field_val[FIELD_W-1-BIT_EQ] = same_value_flag;
      field_val[FIELD_W-1-BIT_SO] = xer_summary_ovf;
      dest_field = target_cr_field_sel;
      do_cr      = 1'b1;
    end else if (op_valid && cnt_64 && !IMPL_64) begin
      ill_d = 1'b1;
    end else if (op_valid && is_cnt) begin
      res_d    = {{(WORD_W-CNT_W){1'b0}}, lz_cnt};
      cnt_wr_d = 1'b1;
      // Count is never negative, so the less-than bit is always clear
      field_val[FIELD_W-1-BIT_LT] = 1'b0;
      field_val[FIELD_W-1-BIT_GT] = (lz_cnt != 7'h00);
      field_val[FIELD_W-1-BIT_EQ] = (lz_cnt == 7'h00);
      field_val[FIELD_W-1-BIT_SO] = xer_summary_ovf;
      dest_field = FIRST_FIELD;
      do_cr      = record_flag;
    end
    if (do_cr) begin
      cr_d[CR_W-1-FIELD_W*dest_field -: FIELD_W] = field_val;
      cr_wr_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cr_q     <= CR_RST;
      res_q    <= GPR_RST;
      cnt_wr_q <= 1'b0;
      cr_wr_q  <= 1'b0;
      ill_q    <= 1'b0;
    end else begin
      cr_q     <= cr_d;
      res_q    <= res_d;
      cnt_wr_q <= cnt_wr_d;
      cr_wr_q  <= cr_wr_d;
      ill_q    <= ill_d;
    end
  end

  assign cond_reg      = cr_q;
  assign count_result  = res_q;
  assign count_wr      = cnt_wr_q;
  assign cr_wr         = cr_wr_q;
  assign illegal_instr = ill_q;

  // Checks
  // Reference counts scanned from the top bit down, and the fields a compare must keep
  logic [CNT_W-1:0]   ref_cntw;
  logic [CNT_W-1:0]   ref_cntd;
  logic               ref_hitw;
  logic               ref_hitd;
  logic [CR_W-1:0]    keep_mask;

  always_comb begin
    ref_cntw  = '0;
    ref_cntd  = '0;
    ref_hitw  = 1'b0;
    ref_hitd  = 1'b0;
    keep_mask = '1;
    for (int k = WORD_W - 1; k >= 0; k--) begin
      ref_hitd = ref_hitd | count_input_gpr[k];
      if (!ref_hitd) begin
        ref_cntd = ref_cntd + 1'b1;
      end
      if (k < HALF_W) begin
        ref_hitw = ref_hitw | count_input_gpr[k];
        if (!ref_hitw) begin
          ref_cntw = ref_cntw + 1'b1;
        end
      end
    end
    for (int f = 0; f < NFIELDS; f++) begin
      if (f == int'(target_cr_field_sel)) begin
        keep_mask[CR_W-1-FIELD_W*f -: FIELD_W] = '0;
      end
    end
  end

  cmp_onehot_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cmp |=> $onehot(cr_q[CR_W-1-FIELD_W*$past(target_cr_field_sel) -: 3]))
    else $error("compare did not set exactly one flag");
  cmpl_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPL && !width_sel && left_input_gpr[31:0] > right_input_gpr[31:0]
    |=> cr_q[CR_W-2-FIELD_W*$past(target_cr_field_sel)])
    else $error("unsigned compare greater flag wrong");
  cmpi_sign_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPI && !width_sel && left_input_gpr[31] && !imm_field[15]
    |=> cr_q[CR_W-1-FIELD_W*$past(target_cr_field_sel)])
    else $error("signed immediate compare less flag wrong");
  cmpli_ext_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPLI && left_input_gpr[31:16] != 16'h0000
    |=> cr_q[CR_W-2-FIELD_W*$past(target_cr_field_sel)])
    else $error("immediate not zero extended");
  cmp_other_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cmp && target_cr_field_sel != FIRST_FIELD |=> cr_q[CR_W-1 -: FIELD_W] == $past(cr_q[CR_W-1 -: FIELD_W]))
    else $error("field zero changed by compare to other field");
  cntw_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTW |=> count_wr && count_result <= 64'h20 &&
      ((count_result == 64'h20) == ($past(count_input_gpr[31:0]) == 32'h0000_0000)))
    else $error("word count out of range");
  cntd_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTD && count_input_gpr[63] |=> count_result == 64'h0)
    else $error("doubleword count with top bit set not zero");
  norec_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cnt && !record_flag |=> cr_q == $past(cr_q) && !cr_wr)
    else $error("unrecorded count touched condition field");
  rec_lt_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cnt && record_flag |=> !cr_q[CR_W-1] && cr_q[CR_W-4] == $past(xer_summary_ovf))
    else $error("recorded count field zero wrong");
  cmp_so_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cmp |=> cr_q[CR_W-4-FIELD_W*$past(target_cr_field_sel)] == $past(xer_summary_ovf))
    else $error("summary overflow not copied");
  rec_sign_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cnt && record_flag |=> cr_q[CR_W-3] == (count_result == 64'h0))
    else $error("recorded equal bit wrong");
  cmpi_equal_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPI && width_sel &&
      left_input_gpr == {{(WORD_W-IMM_W){imm_field[IMM_W-1]}}, imm_field}
    |=> cr_q[CR_W-3-FIELD_W*$past(target_cr_field_sel)])
    else $error("signed immediate compare equal flag wrong");
  cmpl_less_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPL && width_sel && left_input_gpr < right_input_gpr
    |=> cr_q[CR_W-1-FIELD_W*$past(target_cr_field_sel)])
    else $error("unsigned compare less flag wrong");
  cmpli_equal_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPLI && width_sel && left_input_gpr == {{(WORD_W-IMM_W){1'b0}}, imm_field}
    |=> cr_q[CR_W-3-FIELD_W*$past(target_cr_field_sel)])
    else $error("unsigned immediate compare equal flag wrong");
  cmpli_narrow_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CMPLI && !width_sel &&
      left_input_gpr[HALF_W-1:0] == {{(HALF_W-IMM_W){1'b0}}, imm_field}
    |=> cr_q[CR_W-3-FIELD_W*$past(target_cr_field_sel)])
    else $error("narrow unsigned immediate compare equal flag wrong");
  cmp_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cmp |=> cr_wr && !count_wr && count_result == $past(count_result))
    else $error("compare write pulses wrong");
  cmp_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cmp |=> (cr_q & $past(keep_mask)) == ($past(cr_q) & $past(keep_mask)))
    else $error("compare changed a field it did not select");
  cr_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cr_wr |-> cond_reg == $past(cond_reg))
    else $error("condition register changed without a write");
  idle_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    !op_valid || op_sel == CLZ_OP_NONE |=> !cr_wr && !count_wr && !illegal_instr)
    else $error("write pulse without an operation");
  cnt_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !count_wr |-> count_result == $past(count_result))
    else $error("count result changed without a write");
  cntw_exact_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTW |=> count_result == {{(WORD_W-CNT_W){1'b0}}, $past(ref_cntw)})
    else $error("word count value wrong");
  cntw_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTW && count_input_gpr[HALF_W-1] |=> count_result == '0)
    else $error("word count with top word bit set not zero");
  cntw_rec_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTW && record_flag |=> cr_wr && count_wr)
    else $error("recorded word count did not update field zero");
  rec_rest_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cnt && record_flag |=> cr_q[CR_W-FIELD_W-1:0] == $past(cr_q[CR_W-FIELD_W-1:0]))
    else $error("recorded count touched a field other than zero");
  cntd_exact_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTD && IMPL_64 |=> count_result == {{(WORD_W-CNT_W){1'b0}}, $past(ref_cntd)})
    else $error("doubleword count value wrong");
  cntd_legal_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTD |=> illegal_instr == !IMPL_64 && count_wr == IMPL_64)
    else $error("doubleword count legality wrong");
  cntd_rec_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_sel == CLZ_OP_CNTD && IMPL_64 && record_flag |=> cr_wr && !cond_reg[CR_W-1])
    else $error("recorded doubleword count less flag set");
  rec_greater_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && is_cnt && record_flag |=> cr_q[CR_W-2] == (count_result != '0))
    else $error("recorded greater bit wrong");

  cmp_seen_c:  cover property (@(posedge clk) disable iff (!arst_n) op_valid && is_cmp && target_cr_field_sel == 3'h7);
  cntw_max_c:  cover property (@(posedge clk) disable iff (!arst_n) op_valid && op_sel == CLZ_OP_CNTW && count_input_gpr[31:0] == 32'h0);
  cntd_rec_c:  cover property (@(posedge clk) disable iff (!arst_n) op_valid && op_sel == CLZ_OP_CNTD && record_flag);
  cmp_narrow_c: cover property (@(posedge clk) disable iff (!arst_n) op_valid && is_cmp && !width_sel);
  back_to_back_c: cover property (@(posedge clk) disable iff (!arst_n) op_valid && is_cmp ##1 op_valid && is_cnt);

endmodule : clz_unit

/* verification/clz_gpr_model.sv */
// Purpose: Register file side that feeds operands to the compare and count slice
// Assumes: Operands are loaded one cycle before the operation is issued
// Notes:   Read ports come straight from the held registers, as a register file would
`timescale 1ns/100ps
module clz_gpr_model
  import clz_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ld_en,
  input  wire logic [WORD_W-1:0] ld_a,
  input  wire logic [WORD_W-1:0] ld_b,
  output logic      [WORD_W-1:0] left_input_gpr,
  output logic      [WORD_W-1:0] right_input_gpr,
  output logic      [WORD_W-1:0] count_input_gpr
);
  logic [WORD_W-1:0] ra_q;
  logic [WORD_W-1:0] rb_q;
  always_ff @(posedge clk) begin
    if (ld_en) begin
      ra_q <= ld_a;
      rb_q <= ld_b;
    end
  end
  assign left_input_gpr  = ra_q;
  assign right_input_gpr = rb_q;
  assign count_input_gpr = ra_q;
endmodule : clz_gpr_model

/* verification/test_clz_unit.sv */
// Purpose: Self-checking bench for the compare and leading-zero unit
// Assumes: 64-bit implementation, one operation every third cycle apart from one back-to-back pair
// Notes:   Expected condition register is tracked field by field in the bench
`timescale 1ns/100ps
module test_clz_unit
  import clz_pkg::*;
;
  typedef struct packed {
    logic v; clz_op_e op; logic w; logic [2:0] fsel; logic [63:0] a; logic [63:0] b;
    logic [15:0] imm; logic rec; logic so; logic [3:0] fld; logic [6:0] cnt;
  } clz_row_s;
  logic clk, arst_n, op_valid, width_sel, record_flag, xer_summary_ovf, ld_en;
  logic cr_wr, count_wr, illegal_instr;
  clz_op_e op_sel;
  logic [2:0] target_cr_field_sel;
  logic [15:0] imm_field;
  logic [31:0] cond_reg, exp_cr;
  logic [63:0] ld_a, ld_b, left_input_gpr, right_input_gpr, count_input_gpr, count_result;
  int num_errors, check_count;
  // Fields: valid, op, width, selector, a, b, imm, record, so, expected field, expected count
  clz_row_s rows [18] = '{
    '{'1, CLZ_OP_CMPI,  '1, 3'h0, 64'hffff_ffff_ffff_ffe7, '0, 16'h0011, '0, '0, 4'h8, '0},
    '{'1, CLZ_OP_CMPI,  '1, 3'h1, 64'h5, '0, 16'hffff, '0, '1, 4'h5, '0},
    '{'1, CLZ_OP_CMPI,  '0, 3'h5, 64'h1_ffff_ffff, '0, 16'h0000, '0, '0, 4'h8, '0},
    '{'1, CLZ_OP_CMPL,  '1, 3'h2, 64'hffff_0000, 64'h7fff_0000, '0, '0, '0, 4'h4, '0},
    '{'1, CLZ_OP_CMPL,  '1, 3'h7, 64'h10, 64'h10, '0, '0, '1, 4'h3, '0},
    '{'1, CLZ_OP_CMPL,  '1, 3'h6, 64'h1, 64'hffff_ffff_ffff_ffff, '0, '0, '0, 4'h8, '0},
    '{'1, CLZ_OP_CMPLI, '1, 3'h3, 64'hff, '0, 16'h00ff, '0, '0, 4'h2, '0},
    '{'1, CLZ_OP_CMPLI, '1, 3'h4, 64'h1_0000, '0, 16'hffff, '0, '0, 4'h4, '0},
    '{'1, CLZ_OP_CNTW,  '1, 3'h3, 64'h0061_9920, '0, '0, '1, '1, 4'h5, 7'h09},
    '{'1, CLZ_OP_CNTW,  '1, 3'h2, 64'hffff_ffff_0000_0000, '0, '0, '1, '0, 4'h4, 7'h20},
    '{'1, CLZ_OP_CNTD,  '1, 3'h1, 64'h0, '0, '0, '1, '0, 4'h4, 7'h40},
    '{'1, CLZ_OP_CNTD,  '1, 3'h0, 64'h8000_0000_0000_0000, '0, '0, '1, '1, 4'h3, 7'h00},
    '{'1, CLZ_OP_CNTD,  '1, 3'h0, 64'h1, '0, '0, '0, '0, 4'h2, 7'h3f},
    '{'1, CLZ_OP_CMPL,  '0, 3'h5, 64'h1_0000_0002, 64'hffff_ffff_0000_0001, '0, '0, '0, 4'h4, '0},
    '{'1, CLZ_OP_CMPI,  '1, 3'h6, 64'hffff_ffff_ffff_8000, '0, 16'h8000, '0, '0, 4'h2, '0},
    '{'1, CLZ_OP_CMPLI, '0, 3'h2, 64'h5_0000_00ff, '0, 16'h00ff, '0, '1, 4'h3, '0},
    '{'1, CLZ_OP_CNTW,  '1, 3'h0, 64'h8000_0000, '0, '0, '1, '0, 4'h2, 7'h00},
    '{'0, CLZ_OP_CMPI,  '1, 3'h6, 64'h0, '0, 16'h0001, '0, '0, 4'h8, '0}};
  clz_gpr_model i_clz_gpr_model (.clk(clk), .ld_en(ld_en), .ld_a(ld_a), .ld_b(ld_b),
    .left_input_gpr(left_input_gpr), .right_input_gpr(right_input_gpr), .count_input_gpr(count_input_gpr));
  clz_unit i_clz_unit (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_sel(op_sel), .width_sel(width_sel),
    .target_cr_field_sel(target_cr_field_sel), .left_input_gpr(left_input_gpr),
    .right_input_gpr(right_input_gpr), .count_input_gpr(count_input_gpr), .imm_field(imm_field),
    .record_flag(record_flag), .xer_summary_ovf(xer_summary_ovf), .cond_reg(cond_reg),
    .count_result(count_result), .count_wr(count_wr), .cr_wr(cr_wr), .illegal_instr(illegal_instr));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // Load operands, issue one operation, then check the registered answer
  task automatic run_row(input clz_row_s r);
    logic cnt, crw;
    cnt = r.op inside {CLZ_OP_CNTW, CLZ_OP_CNTD};
    crw = r.v && r.op != CLZ_OP_NONE && (!cnt || r.rec);
    @(posedge clk);
    ld_en <= 1'b1; ld_a <= r.a; ld_b <= r.b;
    @(posedge clk);
    ld_en <= 1'b0; op_valid <= r.v; op_sel <= r.op; width_sel <= r.w & IMPL_64;
    target_cr_field_sel <= r.fsel; imm_field <= r.imm; record_flag <= r.rec; xer_summary_ovf <= r.so;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    if (crw) exp_cr[31-4*(cnt ? 0 : r.fsel) -: 4] = r.fld;
    check(cr_wr, crw);
    check(count_wr, r.v && cnt);
    check(cond_reg, exp_cr);
    if (r.v && cnt) check(count_result, {57'h0, r.cnt});
    check(illegal_instr, 1'b0);
  endtask : run_row
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(400*100);
    num_errors++;
    final_report();
  end
  initial begin
    {arst_n, op_valid, width_sel, record_flag, xer_summary_ovf, ld_en} = '0;
    {target_cr_field_sel, imm_field, ld_a, ld_b, exp_cr} = '0;
    op_sel = CLZ_OP_NONE;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    run_row('{'1, CLZ_OP_NONE, '1, 3'h0, '0, '0, '0, '1, '0, '0, '0});
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    check(cond_reg, 32'h0);
    check(count_result, 64'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    exp_cr = '0;
    run_row(rows[1]);
    // Back-to-back compare then recorded word count on the same operands
    @(posedge clk);
    ld_en <= 1'b1; ld_a <= 64'h10; ld_b <= 64'h20;
    @(posedge clk);
    ld_en <= 1'b0; op_valid <= 1'b1; op_sel <= CLZ_OP_CMPL; width_sel <= 1'b1;
    target_cr_field_sel <= 3'h4; xer_summary_ovf <= 1'b0; record_flag <= 1'b1;
    @(posedge clk);
    op_sel <= CLZ_OP_CNTW;
    #1;
    exp_cr[15:12] = 4'h8;
    check(cond_reg, exp_cr);
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    exp_cr[31:28] = 4'h4;
    check(cond_reg, exp_cr);
    check(count_result, 64'h1b);
    final_report();
  end
endmodule : test_clz_unit
